// ===== bench/smc_checker.sv
`timescale 1ns/10ps
module smc_checker
    import smc_pkg::*;
(
    input wire logic                    clk, rst, reg_wr, double_speed,
    input wire logic                    in_valid, in_ready, out_valid,
    input wire logic [7:0]              reg_addr, reg_wdata, reg_rdata,
    input wire logic [5:0]              clip_threshold_high,
    input wire logic [4:0]              pwm_ratio,
    input wire logic [SMC_SAMPLE_W-1:0] in_sample, out_sample
);
    localparam logic [4:0] RT [8] =
        '{5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18};
    logic [7:0]         mid, low, ana;
    logic signed [24:0] t;
    assign t = {5'h00, clip_threshold_high, mid, low[7:2]};
    // shadow registers; only plain writes move them
    always_ff @(posedge clk) begin
        if (rst) begin
            mid <= SMC_RST_MID;
            low <= SMC_RST_LOW;
            ana <= SMC_RST_ANALOG;
        end else if (reg_wr) begin
            if (reg_addr == SMC_OFS_MID) mid <= reg_wdata;
            if (reg_addr == SMC_OFS_LOW) low <= reg_wdata;
            if (reg_addr == SMC_OFS_RATE) ana <= reg_wdata;
        end
    end
    function automatic logic [23:0] clp(input logic [23:0] s);
        return $signed({s[23], s}) > t ? t[23:0] :
            $signed({s[23], s}) < -t ? 24'(-t) : s;
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_mid; reg_wr && reg_addr == SMC_OFS_MID ##1
        reg_addr == SMC_OFS_MID |-> reg_rdata == $past(reg_wdata); endproperty
    a_mid: assert property (p_mid) else $error("mid readback");
    property p_low; reg_wr && reg_addr == SMC_OFS_LOW ##1
        reg_addr == SMC_OFS_LOW |-> reg_rdata == $past(reg_wdata); endproperty
    a_low: assert property (p_low) else $error("low readback");
    property p_lim; out_valid |-> $signed({out_sample[23], out_sample}) <= t
        && $signed({out_sample[23], out_sample}) >= -t; endproperty
    a_lim: assert property (p_lim) else $error("over limit");
    property p_rst; $fell(rst) && !double_speed |-> pwm_ratio == 5'h10;
    endproperty
    a_rst: assert property (p_rst) else $error("reset ratio");
    property p_rate; pwm_ratio == (RT[ana[6:4]] >> double_speed); endproperty
    a_rate: assert property (p_rate) else $error("ratio map");
    property p_clip; in_valid && in_ready && !out_valid |=>
        out_valid && out_sample == clp($past(in_sample)); endproperty
    a_clip: assert property (p_clip) else $error("clip value");
endmodule
bind smc_clipper smc_checker smc_checker_i (.clk, .rst, .reg_wr,
    .double_speed, .in_valid, .in_ready, .out_valid, .reg_addr, .reg_wdata,
    .reg_rdata, .clip_threshold_high, .pwm_ratio, .in_sample, .out_sample);

// ===== bench/test_sample_magnitude_clipper.sv
`timescale 1ns/10ps
module test_sample_magnitude_clipper
    import smc_pkg::*;
;
    logic        clk = 0, rst = 1, reg_wr = 0, double_speed = 0;
    logic        in_valid = 0, out_ready = 0, in_ready, out_valid;
    logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [5:0]  clip_threshold_high = 0;
    logic [4:0]  pwm_ratio;
    logic [23:0] in_sample = 0, out_sample;
    int          fails = 0, cmp_count = 0, cyc = 0;
    logic signed [24:0] t = 25'h00448D;
    logic [4:0]  rt [8] = '{5'h06,5'h08,5'h0A,5'h0C,5'h0E,5'h10,5'h14,5'h18};
    logic [23:0] smp [8] = '{24'h7FFFFF, 24'h800000, 24'h00448D, 24'h00448E,
        24'hFFBB73, 24'hFFBB72, 24'h000001, 24'hFFFFFF};
    always #5 clk = ~clk;
    smc_clipper smc_clipper_i (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata,
        .reg_rdata, .clip_threshold_high, .double_speed, .pwm_ratio,
        .in_valid, .in_ready, .in_sample, .out_valid, .out_ready, .out_sample);
    task automatic chk(input logic [23:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk) reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge clk) reg_addr = a;
        #1 chk(reg_rdata, e);
    endtask
    function automatic logic [23:0] clp(input logic [23:0] s);
        return $signed({s[23], s}) > t ? t[23:0] :
            $signed({s[23], s}) < -t ? 24'(-t) : s;
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // a hang is cut short well past the fifty or so cycles needed
    always @(posedge clk) if (++cyc > 2000) begin
        fails++;
        conclude();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 0;
        rd(SMC_OFS_MID, SMC_RST_MID);
        rd(SMC_OFS_LOW, SMC_RST_LOW);
        rd(SMC_OFS_RATE, 8'h55);
        chk(pwm_ratio, 5'h10);
        rd(8'h20, 8'h00);
        chk(out_valid, 0);
        chk(in_ready, 1);
        $display("reset test done");
        for (int c = 0; c < 8; c++) begin
            wr(SMC_OFS_RATE, {1'b0, 3'(c), 4'h5});
            double_speed = 0;
            #1 chk(pwm_ratio, rt[c]);
            double_speed = 1;
            #1 chk(pwm_ratio, rt[c] >> 1);
        end
        double_speed = 0;
        $display("rate test done");
        clip_threshold_high = 6'h01;
        wr(SMC_OFS_MID, 8'h12);
        wr(SMC_OFS_LOW, 8'h34);
        rd(SMC_OFS_MID, 8'h12);
        rd(SMC_OFS_LOW, 8'h34);
        // a write to an unmapped offset must leave the threshold alone
        wr(8'h20, 8'h00);
        rd(SMC_OFS_MID, 8'h12);
        rd(SMC_OFS_LOW, 8'h34);
        // fill with the far side stalled, then drain
        foreach (smp[i]) @(negedge clk) {in_valid, in_sample} = {1'b1, smp[i]};
        @(negedge clk) in_valid = 0;
        chk(in_ready, 0);
        out_ready = 1;
        foreach (smp[i]) begin
            chk(out_valid, 1);
            chk(out_sample, clp(smp[i]));
            @(negedge clk);
        end
        chk(out_valid, 0);
        $display("clip test done");
        conclude();
    end
endmodule

// ===== logic/smc_clipper.sv
`timescale 1ns/10ps
module smc_clipper
    import smc_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // register port
    input  wire logic                    reg_wr,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    output logic      [7:0]              reg_rdata,
    // upper threshold bits from elsewhere
    input  wire logic [5:0]              clip_threshold_high,
    // single or double speed
    input  wire logic                    double_speed,
    // switching-rate ratio out
    output logic      [4:0]              pwm_ratio,
    // sample input stream
    input  wire logic                    in_valid,
    output logic                         in_ready,
    input  wire logic [SMC_SAMPLE_W-1:0] in_sample,
    // sample output to converter
    output logic                         out_valid,
    input  wire logic                    out_ready,
    output logic      [SMC_SAMPLE_W-1:0] out_sample
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0]              clip_threshold_mid_bits;
    logic [7:0]              clip_threshold_low_bits;
    logic [7:0]              analog_ctrl;
    logic [SMC_LEVEL_W-1:0]  clip_threshold;
    logic signed [SMC_SAMPLE_W-1:0] pos_lim;
    logic signed [SMC_SAMPLE_W-1:0] neg_lim;
    logic signed [SMC_SAMPLE_W-1:0] next_sample;
    logic                    fifo_ready;
    logic                    held_valid;

    // threshold mid bits
    always_ff @(posedge clk) begin
        if (rst) begin
            clip_threshold_mid_bits <= SMC_RST_MID;
        end else if (reg_wr && reg_addr == SMC_OFS_MID) begin
            clip_threshold_mid_bits <= reg_wdata;
        end
    end

    // low bits; reserved bits stored as written, host keeps them 00
    always_ff @(posedge clk) begin
        if (rst) begin
            clip_threshold_low_bits <= SMC_RST_LOW;
        end else if (reg_wr && reg_addr == SMC_OFS_LOW) begin
            clip_threshold_low_bits <= reg_wdata;
        end
    end

    // analog control, only rate field used here
    always_ff @(posedge clk) begin
        if (rst) begin
            analog_ctrl <= SMC_RST_ANALOG;
        end else if (reg_wr && reg_addr == SMC_OFS_RATE) begin
            analog_ctrl <= reg_wdata;
        end
    end

    // readback; unmapped offsets read zero
    always_comb begin
        unique case (reg_addr)
            SMC_OFS_MID:  reg_rdata = clip_threshold_mid_bits;
            SMC_OFS_LOW:  reg_rdata = clip_threshold_low_bits;
            SMC_OFS_RATE: reg_rdata = analog_ctrl;
            default:      reg_rdata = 8'h00;
        endcase
    end

    // ratio lookup, halved in double speed
    always_comb begin
        unique case (analog_ctrl[SMC_RATE_LSB +: 3])
            3'h0:    pwm_ratio = 5'h06;
            3'h1:    pwm_ratio = 5'h08;
            3'h2:    pwm_ratio = 5'h0A;
            3'h3:    pwm_ratio = 5'h0C;
            3'h4:    pwm_ratio = 5'h0E;
            3'h5:    pwm_ratio = 5'h10;
            3'h6:    pwm_ratio = 5'h14;
            default: pwm_ratio = 5'h18;
        endcase
        if (double_speed) begin
            pwm_ratio = pwm_ratio >> 1;
        end
    end

    // ****************************************
    // clipping
    // ****************************************
    assign clip_threshold = {clip_threshold_high, clip_threshold_mid_bits,
                             clip_threshold_low_bits[7:SMC_LOW_LSB]};
    assign pos_lim = $signed({{(SMC_SAMPLE_W-SMC_LEVEL_W){1'b0}},
                              clip_threshold});
    assign neg_lim = -pos_lim;

    // symmetric saturation; stalls when fifo full
    always_comb begin
        next_sample = $signed(in_sample);
        if ($signed(in_sample) > pos_lim) begin
            next_sample = pos_lim;
        end else if ($signed(in_sample) < neg_lim) begin
            next_sample = neg_lim;
        end
    end
    assign in_ready = fifo_ready;
    assign held_valid = in_valid;

    smc_fifo #(
        .WIDTH (SMC_SAMPLE_W),
        .DEPTH (SMC_FIFO_DEPTH)
    ) smc_fifo_i (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (held_valid),
        .in_ready  (fifo_ready),
        .in_data   (next_sample),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_sample)
    );
endmodule

// ===== logic/smc_fifo.sv
`timescale 1ns/10ps
module smc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // write side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // read side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty
    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ===== logic/smc_pkg.sv
package smc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] SMC_OFS_MID      = 8'h10;
    localparam logic [7:0] SMC_OFS_LOW      = 8'h11;
    localparam logic [7:0] SMC_OFS_RATE     = 8'h06;
    localparam logic [7:0] SMC_RST_MID      = 8'hFF;
    localparam logic [7:0] SMC_RST_LOW      = 8'hFC;
    localparam logic [7:0] SMC_RST_ANALOG   = 8'h55;
    localparam int         SMC_LOW_LSB      = 2;
    localparam int         SMC_RATE_LSB     = 4;
    localparam logic [2:0] SMC_RST_RATE     = 3'h5;
    localparam logic [7:0] SMC_RATE_MASK    = 8'h70;
    // ****************************************
    // datapath
    // ****************************************
    localparam int         SMC_LEVEL_W      = 20;
    localparam int         SMC_SAMPLE_W     = 24;
    localparam int         SMC_FIFO_DEPTH   = 8;
endpackage
